// ### sim/pftc_load_model.sv
// behavioural model of the portable devices loading both ports
`timescale 1ns/1ps
module pftc_load_model (
  input  wire logic [1:0] switch_close_in, // switch state per port
  input  wire logic [3:0] draw_in,         // load per port: 0 idle, 1 over, 2 ceiling, 3 sag
  output logic      [1:0] over_limit_out,  // current above limit
  output logic      [1:0] at_ceiling_out,  // current at ceiling
  output logic      [1:0] vbus_low_out     // bus below keep-out
);
  // an open switch leaves the bus unpowered, so it reads low like a real port
  always_comb begin
    for (int g = 0; g < 2; g++) begin
      over_limit_out[g] = switch_close_in[g] && draw_in[g*2+:2] != 2'h0;
      at_ceiling_out[g] = switch_close_in[g] && draw_in[g*2+:2] == 2'h2;
      vbus_low_out[g]   = !switch_close_in[g] || draw_in[g*2+:2] == 2'h3;
    end
  end
endmodule : pftc_load_model

// ### sim/pftc_monitor.sv
// assertion checker for the port fault and thermal control block
`timescale 1ns/1ps
module pftc_monitor #(
  parameter int NUM_PORTS   = 2,
  parameter int MASK_CYCLES = 8
) (
  input wire logic                   clk_in,                // clock
  input wire logic                   srst_in,               // reset
  input wire logic [NUM_PORTS*3-1:0] port_current_limit_in, // limit codes
  input wire logic [NUM_PORTS-1:0]   at_ceiling_in,         // ceiling flags
  input wire logic                   stage1_hot_in,         // stage1 heat
  input wire logic                   stage1_cool_in,        // stage1 release
  input wire logic                   stage2_hot_in,         // stage2 heat
  input wire logic                   stage2_cool_in,        // stage2 release
  input wire logic [NUM_PORTS-1:0]   switch_close_out,      // switches
  input wire logic [NUM_PORTS-1:0]   cc_mode_out,           // cc mode
  input wire logic [NUM_PORTS-1:0]   error_out,             // error state
  input wire logic [NUM_PORTS-1:0]   overcurrent_flag_out,  // overcurrent
  input wire logic [NUM_PORTS-1:0]   thermal_flag_out,      // thermal
  input wire logic [NUM_PORTS-1:0]   alert_n_out,           // alert level
  input wire logic [NUM_PORTS-1:0]   alert_n_oe_out         // alert drive
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (srst_in);
  // outputs register from the previous cycle's limit, hence $past
  property p_cc_limit; cc_mode_out[0] |-> $past(port_current_limit_in[2:0]) <= 3'h4; endproperty
  a_cc_limit: assert property (p_cc_limit) else $error("cc with high limit");
  property p_cc_closed; (cc_mode_out & ~switch_close_out) == '0; endproperty
  a_cc_closed: assert property (p_cc_closed) else $error("cc with open switch");
  property p_err_open; (error_out & switch_close_out) == '0; endproperty
  a_err_open: assert property (p_err_open) else $error("error with closed switch");
  property p_err_alert; alert_n_oe_out == error_out && alert_n_out == '0; endproperty
  a_err_alert: assert property (p_err_alert) else $error("alert mismatch");
  // four edges of latency, four samples then the next cover it with no cycle spare
  property p_s2_open; stage2_hot_in [*4] |=> switch_close_out == '0; endproperty
  a_s2_open: assert property (p_s2_open) else $error("stage2 left switch closed");
  property p_s2_err; stage2_hot_in [*4] |=> &error_out; endproperty
  a_s2_err: assert property (p_s2_err) else $error("stage2 missing error");
  property p_ovc_mask; $rose(overcurrent_flag_out[0]) && $past(cc_mode_out[0]) |-> $past(at_ceiling_in[0], MASK_CYCLES); endproperty
  a_ovc_mask: assert property (p_ovc_mask) else $error("overcurrent before mask");
  // two synchroniser edges, one state edge: the open shows by the third sample
  property p_s1_cc; cc_mode_out[0] && stage1_hot_in |-> ##[1:3] !switch_close_out[0]; endproperty
  a_s1_cc: assert property (p_s1_cc) else $error("stage1 kept cc port");
  property p_th_hold; thermal_flag_out[0] && !stage1_cool_in && !stage2_cool_in |=> !switch_close_out[0]; endproperty
  a_th_hold: assert property (p_th_hold) else $error("thermal hold broken");
  c_cc: cover property (cc_mode_out[0]);
  c_both_err: cover property (&error_out);
  c_ovc: cover property ($rose(overcurrent_flag_out[0]));
endmodule : pftc_monitor

bind pftc_top pftc_monitor #(.NUM_PORTS(NUM_PORTS), .MASK_CYCLES(MASK_CYCLES)) u_mon (.*);

// ### sim/test_pftc_top.sv
// self-checking bench for the port fault and thermal control block
`timescale 1ns/1ps
module test_pftc_top;
  import pftc_pkg::*;
  localparam int MASK = 8; // short mask keeps the run brief
  logic       clk_in = 0, srst_in = 1, stage1_hot_in = 0, stage1_cool_in = 1, stage2_hot_in = 0, stage2_cool_in = 1;
  logic [1:0] port_power_request_in = 2'h0;
  logic [5:0] port_current_limit_in = {PFTC_LIMIT_RESET, PFTC_LIMIT_RESET};
  logic [3:0] draw = 4'h0;
  logic [1:0] over_limit_in, at_ceiling_in, vbus_low_in, switch_close_out, cc_mode_out, error_out;
  logic [1:0] overcurrent_flag_out, keepout_flag_out, thermal_flag_out, alert_n_out, alert_n_oe_out;
  int         fails = 0, samples_checked = 0;
  pftc_top #(.MASK_CYCLES(MASK)) dut (.*);
  pftc_load_model u_load (.switch_close_in(switch_close_out), .draw_in(draw), .over_limit_out(over_limit_in),
                          .at_ceiling_out(at_ceiling_in), .vbus_low_out(vbus_low_in));
  initial forever #5 clk_in = ~clk_in;
  task automatic check(input string what, input logic [1:0] seen, input logic [1:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("Error %s expected %b seen %b", what, exp, seen);
    end
  endtask : check
  // inputs move at falling edges only
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_in);
  endtask : cyc
  // error exit needs request low and both releases seen
  task automatic idle();
    port_power_request_in = 2'h0;
    draw = 4'h0;
    stage1_hot_in = 0;
    stage2_hot_in = 0;
    stage1_cool_in = 1;
    stage2_cool_in = 1;
    cyc(8);
    check("idle error", error_out, 2'h0);
  endtask : idle
  task automatic t_trip();
    port_current_limit_in = {PFTC_LIMIT_RESET, PFTC_LIMIT_CC_MAX + 3'h1}; // first code above cc range
    port_power_request_in = 2'h1;
    cyc(1);
    check("switch", switch_close_out, 2'h1);
    draw = 4'h1;
    cyc(6);
    check("cc", cc_mode_out, 2'h0);
    check("switch", switch_close_out, 2'h0);
    check("overcurrent", overcurrent_flag_out, 2'h1);
    check("alert", alert_n_oe_out, 2'h1);
    idle();
    $display("trip test done");
  endtask : t_trip
  task automatic t_cc(input logic [1:0] load, input logic kout);
    port_current_limit_in = {PFTC_LIMIT_RESET, PFTC_LIMIT_CC_MAX};
    port_power_request_in = 2'h1;
    draw = 4'h1;
    cyc(6);
    check("cc", cc_mode_out, 2'h1);
    check("switch", switch_close_out, 2'h1);
    draw = {2'h0, load};
    cyc(5);
    check("early error", error_out, 2'h0);
    cyc(12);
    check("error", error_out, 2'h1);
    check("switch", switch_close_out, 2'h0);
    check("overcurrent", overcurrent_flag_out, {1'b0, !kout});
    check("keepout", keepout_flag_out, {1'b0, kout});
    idle();
    $display("cc test done");
  endtask : t_cc
  task automatic t_heat(input logic second);
    port_current_limit_in = {PFTC_LIMIT_RESET, PFTC_LIMIT_CC_MAX};
    port_power_request_in = 2'h3;
    draw = 4'h1;
    cyc(6);
    stage1_hot_in = !second;
    stage2_hot_in = second;
    stage1_cool_in = second;
    stage2_cool_in = 0;
    cyc(5);
    check("switch", switch_close_out, second ? 2'h0 : 2'h2);
    check("thermal", thermal_flag_out, second ? 2'h3 : 2'h1);
    check("alert", alert_n_oe_out, second ? 2'h3 : 2'h1);
    port_power_request_in = 2'h1;
    cyc(2);
    port_power_request_in = 2'h3;
    cyc(3);
    check("refused", error_out, 2'h3);
    port_power_request_in = 2'h0;
    draw = 4'h0;
    stage1_hot_in = 0;
    stage2_hot_in = 0;
    cyc(8);
    check("held", error_out, 2'h3);
    idle();
    $display("heat test done");
  endtask : t_heat
  // a hot die at power-up with both enables already high must refuse both ports
  task automatic t_powerup();
    port_power_request_in = 2'h3;
    stage1_hot_in = 1;
    stage1_cool_in = 0;
    srst_in = 1;
    cyc(8);
    check("reset error", error_out, 2'h0);
    srst_in = 0;
    cyc(6);
    check("power-up refused", error_out, 2'h3);
    check("switch", switch_close_out, 2'h0);
    check("thermal", thermal_flag_out, 2'h3);
    idle();
    $display("power-up test done");
  endtask : t_powerup
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : tally_and_finish
  // the whole run needs well under a thousand cycles
  initial begin
    repeat (3000) @(posedge clk_in);
    fails++;
    tally_and_finish();
  end
  initial begin
    cyc(8);
    srst_in = 0;
    cyc(4); // requests are ignored until the power-up settle has passed
    t_trip();
    t_cc(2'h2, 1'b0);
    t_cc(2'h3, 1'b1);
    t_heat(1'b0);
    t_heat(1'b1);
    t_powerup();
    tally_and_finish();
  end
endmodule : test_pftc_top

// ### verilog/pftc_pkg.sv
// shared constants and types for the port fault and thermal control block
package pftc_pkg;
  // current limit codes, one step per decode entry; code 4 is the 1.6 A setting
  localparam logic [2:0] PFTC_LIMIT_CC_MAX      = 3'h4;   // highest code allowing constant current
  localparam logic [2:0] PFTC_LIMIT_RESET       = 3'h7;   // default limit, above the ceiling
  // fault mask time in ns and its cycle count at 100 MHz (rounded down, at least one)
  localparam int         PFTC_CLK_PERIOD_NS     = 10;
  localparam int         PFTC_MASK_TIME_NS      = 15000;
  localparam int         PFTC_MASK_CYCLES       = (PFTC_MASK_TIME_NS / PFTC_CLK_PERIOD_NS < 1) ? 1 :
                                                  PFTC_MASK_TIME_NS / PFTC_CLK_PERIOD_NS;
  localparam int         PFTC_MASK_W            = 16;
  // per-channel operating state
  typedef enum logic [1:0] {
    PFTC_OFF   = 2'b00,
    PFTC_TRIP  = 2'b01,
    PFTC_CC    = 2'b10,
    PFTC_ERROR = 2'b11
  } pftc_state_type;
endpackage : pftc_pkg

// ### verilog/pftc_sync.sv
// two-flop synchroniser for a bundle of asynchronous flags
`timescale 1ns/1ps
module pftc_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk_in,  // system clock
  input  wire logic             srst_in, // synchronous reset
  input  wire logic [WIDTH-1:0] d_in,    // asynchronous flags
  output logic      [WIDTH-1:0] q_out    // synchronised flags
);
  logic [WIDTH-1:0] meta;
  logic [WIDTH-1:0] next_meta;
  logic [WIDTH-1:0] next_q;

  // first stage is read only by the second stage
  always_comb begin
    next_meta = srst_in ? '0 : d_in;
    next_q    = srst_in ? '0 : meta;
  end

  always_ff @(posedge clk_in) begin
    meta  <= next_meta;
    q_out <= next_q;
  end
endmodule : pftc_sync

// ### verilog/pftc_top.sv
// per-port limit mode, mask timing and two-stage thermal shutdown control
//
// Function
// - constant current only above limit, limit at most 1.6A
// - constant current keeps switch closed at reduced voltage
// - stage1 heat in CC opens that channel, alerts
// - stage2 heat opens both switches regardless
// - ceiling current beyond mask time gives overcurrent error
// - low bus voltage beyond mask time: open, flag
// - CC allowed only when limit below ceiling
// - below ceiling: trip, then CC, trip on low voltage
// - above ceiling, default: trip opens switch on overlimit
// - CC lasts mask time, stage1 heat opens immediately
// - stage1 hot: enable edge or power-up gives error
// - stage1 error holds until below low hysteresis
// - stage2 event errors and alerts both channels
// - stage2 keeps both open until below high hysteresis
`timescale 1ns/1ps
module pftc_top
  import pftc_pkg::*;
#(
  parameter int NUM_PORTS   = 2,
  parameter int MASK_CYCLES = pftc_pkg::PFTC_MASK_CYCLES
) (
  input  wire logic                 clk_in,                     // 100 MHz clock
  input  wire logic                 srst_in,                    // synchronous reset, high
  input  wire logic [NUM_PORTS-1:0] port_power_request_in,      // per-port enable, active high
  input  wire logic [NUM_PORTS*3-1:0] port_current_limit_in,    // per-port limit code, 3 bits each
  input  wire logic [NUM_PORTS-1:0] over_limit_in,              // current above limit (async)
  input  wire logic [NUM_PORTS-1:0] at_ceiling_in,              // current at profile ceiling (async)
  input  wire logic [NUM_PORTS-1:0] vbus_low_in,                // bus below keep-out voltage (async)
  input  wire logic                 stage1_hot_in,              // die above stage1 threshold (async)
  input  wire logic                 stage1_cool_in,             // die below stage1 minus hyst (async)
  input  wire logic                 stage2_hot_in,              // die above stage2 threshold (async)
  input  wire logic                 stage2_cool_in,             // die below stage2 minus hyst (async)
  output logic      [NUM_PORTS-1:0] switch_close_out,           // close port switch
  output logic      [NUM_PORTS-1:0] cc_mode_out,                // port in constant current
  output logic      [NUM_PORTS-1:0] error_out,                  // port in error state
  output logic      [NUM_PORTS-1:0] overcurrent_flag_out,       // sticky overcurrent event
  output logic      [NUM_PORTS-1:0] keepout_flag_out,           // sticky keep-out violation
  output logic      [NUM_PORTS-1:0] thermal_flag_out,           // sticky thermal event
  output logic      [NUM_PORTS-1:0] alert_n_out,                // fault alert, active low
  output logic      [NUM_PORTS-1:0] alert_n_oe_out              // alert drive enable (open drain)
);
  import pftc_pkg::*;

  localparam int AW = 3 * NUM_PORTS + 4;

  // all analog flags pass the synchroniser before any logic
  logic [AW-1:0] async_flags;
  logic [AW-1:0] sync_flags;
  logic [NUM_PORTS-1:0] s_over, s_ceil, s_low;
  logic s_hot1, s_cool1, s_hot2, s_cool2;

  assign async_flags = {stage2_cool_in, stage2_hot_in, stage1_cool_in, stage1_hot_in,
                        vbus_low_in, at_ceiling_in, over_limit_in};
  assign {s_cool2, s_hot2, s_cool1, s_hot1, s_low, s_ceil, s_over} = sync_flags;

  pftc_sync #(
    .WIDTH (AW)
  ) u_sync (
    .clk_in  (clk_in),
    .srst_in (srst_in),
    .d_in    (async_flags),
    .q_out   (sync_flags)
  );

  // shared thermal latches: stage1 held until cooled past hysteresis, stage2 likewise
  logic stage1_latched, next_stage1_latched;
  logic stage2_latched, next_stage2_latched;

  always_comb begin
    next_stage1_latched = stage1_latched;
    next_stage2_latched = stage2_latched;
    if (s_hot1) begin
      next_stage1_latched = 1'b1;
    end else if (s_cool1) begin
      next_stage1_latched = 1'b0;
    end
    if (s_hot2) begin
      next_stage2_latched = 1'b1;
    end else if (s_cool2) begin
      next_stage2_latched = 1'b0;
    end
    if (srst_in) begin
      next_stage1_latched = 1'b0;
      next_stage2_latched = 1'b0;
    end
  end

  always_ff @(posedge clk_in) begin
    stage1_latched <= next_stage1_latched;
    stage2_latched <= next_stage2_latched;
  end

  // power-up settle: requests wait until the synchronisers and thermal latches carry real
  // levels, otherwise a die already hot at power-up would slip past the refusal
  localparam logic [1:0] SETTLE_DONE = 2'h3;
  logic [1:0] settle_cnt, next_settle_cnt;
  logic       powered;
  always_comb begin
    next_settle_cnt = (settle_cnt == SETTLE_DONE) ? settle_cnt : settle_cnt + 2'h1;
    if (srst_in) begin
      next_settle_cnt = 2'h0;
    end
  end
  always_ff @(posedge clk_in) begin
    settle_cnt <= next_settle_cnt;
  end
  assign powered = (settle_cnt == SETTLE_DONE);

  // one independent state machine per port
  genvar g;
  generate
    for (g = 0; g < NUM_PORTS; g++) begin : g_port
      pftc_state_type     state, next_state;
      logic [PFTC_MASK_W-1:0] ceil_cnt, next_ceil_cnt;
      logic [PFTC_MASK_W-1:0] low_cnt, next_low_cnt;
      logic               req_d, next_req_d;
      logic               oc_f, next_oc_f, ko_f, next_ko_f, th_f, next_th_f;
      logic               cc_ok, req_rise, ceil_done, low_done, thermal_err;
      logic [2:0]         lim;

      assign lim       = port_current_limit_in[g*3 +: 3];
      assign cc_ok     = (lim <= PFTC_LIMIT_CC_MAX);
      assign req_rise  = port_power_request_in[g] && !req_d;
      assign ceil_done = (ceil_cnt >= PFTC_MASK_W'(MASK_CYCLES));
      assign low_done  = (low_cnt >= PFTC_MASK_W'(MASK_CYCLES));
      // reset clears win over hardware sets in every flag below
      assign thermal_err = stage2_latched || (state == PFTC_CC && s_hot1);

      always_comb begin
        next_state    = state;
        next_req_d    = powered && port_power_request_in[g]; // held low until settled: power-up reads as a rise
        next_oc_f     = oc_f;
        next_ko_f     = ko_f;
        next_th_f     = th_f;
        // mask timers run while the condition holds, saturating once done
        next_ceil_cnt = (state == PFTC_CC && s_ceil[g] && !ceil_done) ? ceil_cnt + 1'b1 :
                        (state == PFTC_CC && s_ceil[g]) ? ceil_cnt : '0;
        next_low_cnt  = (state == PFTC_CC && s_low[g] && !low_done) ? low_cnt + 1'b1 :
                        (state == PFTC_CC && s_low[g]) ? low_cnt : '0;
        unique case (state)
          PFTC_OFF: begin
            if (powered && req_rise && (stage1_latched || stage2_latched)) begin
              next_state = PFTC_ERROR;
              next_th_f  = 1'b1;
            end else if (powered && port_power_request_in[g]) begin
              next_state = PFTC_TRIP;
            end
          end
          PFTC_TRIP: begin
            if (!port_power_request_in[g]) begin
              next_state = PFTC_OFF;
            end else if (stage2_latched) begin
              next_state = PFTC_ERROR;
              next_th_f  = 1'b1;
            end else if (s_over[g] && cc_ok) begin
              next_state = PFTC_CC;
            end else if (s_over[g]) begin
              next_state = PFTC_ERROR;
              next_oc_f  = 1'b1;
            end
          end
          PFTC_CC: begin
            // switch stays closed here at reduced voltage
            if (!port_power_request_in[g]) begin
              next_state = PFTC_OFF;
            end else if (thermal_err) begin
              next_state = PFTC_ERROR;
              next_th_f  = 1'b1;
            end else if (low_done) begin
              next_state = PFTC_ERROR;
              next_ko_f  = 1'b1;
            end else if (ceil_done) begin
              next_state = PFTC_ERROR;
              next_oc_f  = 1'b1;
            end else if (!s_over[g] && !s_ceil[g] && !s_low[g]) begin
              next_state = PFTC_TRIP;
            end
          end
          PFTC_ERROR: begin
            // leave only when request drops and no thermal latch holds
            if (!port_power_request_in[g] && !stage1_latched && !stage2_latched) begin
              next_state = PFTC_OFF;
              next_oc_f  = 1'b0;
              next_ko_f  = 1'b0;
              next_th_f  = 1'b0;
            end
          end
        endcase
        if (stage2_latched && state != PFTC_ERROR) begin
          next_state = PFTC_ERROR;
          next_th_f  = 1'b1;
        end
        if (srst_in) begin
          next_state    = PFTC_OFF;
          next_ceil_cnt = '0;
          next_low_cnt  = '0;
          next_req_d    = 1'b0;
          next_oc_f     = 1'b0;
          next_ko_f     = 1'b0;
          next_th_f     = 1'b0;
        end
      end

      always_ff @(posedge clk_in) begin
        state    <= next_state;
        ceil_cnt <= next_ceil_cnt;
        low_cnt  <= next_low_cnt;
        req_d    <= next_req_d;
        oc_f     <= next_oc_f;
        ko_f     <= next_ko_f;
        th_f     <= next_th_f;
      end

      // registered outputs derived from next state so they track state exactly
      logic next_close, next_cc, next_err;
      always_comb begin
        next_close = (next_state == PFTC_TRIP) || (next_state == PFTC_CC);
        next_cc    = (next_state == PFTC_CC);
        next_err   = (next_state == PFTC_ERROR);
      end
      always_ff @(posedge clk_in) begin
        switch_close_out[g]     <= next_close;
        cc_mode_out[g]          <= next_cc;
        error_out[g]            <= next_err;
        overcurrent_flag_out[g] <= next_oc_f;
        keepout_flag_out[g]     <= next_ko_f;
        thermal_flag_out[g]     <= next_th_f;
        alert_n_out[g]          <= 1'b0;                        // pin only ever pulled low
        alert_n_oe_out[g]       <= next_err;
      end
    end
  endgenerate
endmodule : pftc_top
